// *** common/frame_irq_pkg.sv ***
/*
  Constants for the interrupt-mask and frame-interval register bank:
  register offsets, field positions, reset values and timing counts.
  Assumes a 100 MHz register clock and a 12 MHz bit-time rate.
*/
`default_nettype none
package frame_irq_pkg;

  // register indices; the byte address is four times the index
  localparam logic [7:0]  IDX_MASK_SET     = 8'h04;
  localparam logic [7:0]  IDX_MASK_CLEAR   = 8'h05;
  localparam logic [7:0]  IDX_FRAME_LEN    = 8'h0D;
  localparam logic [7:0]  IDX_FRAME_LEFT   = 8'h0E;
  localparam logic [7:0]  IDX_SRC_FLAGS    = 8'h02;
  localparam logic [7:0]  IDX_CMD_STATE    = 8'h08;
  localparam logic [11:0] ADDR_MASK_SET    = {2'h0, IDX_MASK_SET, 2'h0};
  localparam logic [11:0] ADDR_MASK_CLEAR  = {2'h0, IDX_MASK_CLEAR, 2'h0};
  localparam logic [11:0] ADDR_FRAME_LEN   = {2'h0, IDX_FRAME_LEN, 2'h0};
  localparam logic [11:0] ADDR_FRAME_LEFT  = {2'h0, IDX_FRAME_LEFT, 2'h0};
  localparam logic [11:0] ADDR_SRC_FLAGS   = {2'h0, IDX_SRC_FLAGS, 2'h0};
  localparam logic [11:0] ADDR_CMD_STATE   = {2'h0, IDX_CMD_STATE, 2'h0};

  // read and write command codes of the byte command port
  localparam logic [7:0]  CMD_RD_MASK_CLEAR = 8'h05;
  localparam logic [7:0]  CMD_WR_MASK_CLEAR = 8'h85;
  localparam logic [7:0]  CMD_RD_FRAME_LEN  = 8'h0D;
  localparam logic [7:0]  CMD_WR_FRAME_LEN  = 8'h8D;

  // mask / flag layout
  localparam int          GATE_BIT          = 31;
  localparam int          SRC_W             = 7;
  localparam logic [6:0]  SRC_VALID         = 7'h7D; // bit 1 reserved
  localparam int          ROOT_PORT_BIT     = 6;
  localparam int          FRAME_WRAP_BIT    = 5;
  localparam int          FATAL_FAULT_BIT   = 4;
  localparam int          WAKEUP_BIT        = 3;
  localparam int          FRAME_BEGIN_BIT   = 2;
  localparam int          OVERRUN_BIT       = 0;

  // frame-length register fields
  localparam int          LEN_W             = 14;
  localparam int          LEN_LSB           = 0;
  localparam int          MAXB_W            = 15;
  localparam int          MAXB_LSB          = 16;
  localparam int          FLIP_BIT          = 31;
  localparam logic [13:0] LEN_NOMINAL       = 14'h2EDF; // 11999
  localparam logic [14:0] MAXB_RESET        = 15'h0000;
  localparam logic        FLIP_RESET        = 1'b0;

  // command-state register: soft reset bit
  localparam int          SOFT_RESET_BIT    = 0;

  // bit time: 12 MHz bit rate against 100 MHz clock
  localparam int          CLK_HZ            = 100_000_000;
  localparam int          BIT_HZ            = 12_000_000;
  localparam int          BIT_CYCLES        = CLK_HZ / BIT_HZ; // rounds down, 8
  localparam logic [3:0]  BIT_CYC_LAST      = 4'(BIT_CYCLES - 1);

endpackage : frame_irq_pkg
`default_nettype wire

// *** hdl/frame_irq_regs.sv ***
/*
  Interrupt-mask set/clear pair and frame-interval register with its
  bit-time frame counter, reached over apb.
  Assumes a single pclk domain and event inputs synchronous to it.
*/
`timescale 1ns/1ps
`default_nettype none

module frame_irq_regs
  import frame_irq_pkg::*;
#(
  parameter int ADDR_W = 12
)
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [SRC_W-1:0]  src_event,
  output logic                   irq,
  output logic                   frame_begin,
  output logic      [MAXB_W-1:0] max_transfer_count
);

  // elaboration-time refusal: the decoder needs twelve address bits
  if (ADDR_W < 12)
  begin : g_addr_w_check
    $error("ADDR_W must cover the register map");
  end

  ////////////////////////////////////////////////////////////////////////
  // bus decode

  logic wr_en;
  logic rd_en;
  logic hit;
  logic [11:0] addr12;

  assign addr12  = paddr[11:0];
  assign wr_en   = psel && penable && pwrite;
  assign rd_en   = psel && penable && !pwrite;
  assign pready  = 1'b1;                     // zero wait states
  assign hit     = (addr12 == ADDR_MASK_SET)  || (addr12 == ADDR_MASK_CLEAR) ||
                   (addr12 == ADDR_FRAME_LEN) || (addr12 == ADDR_FRAME_LEFT) ||
                   (addr12 == ADDR_SRC_FLAGS) || (addr12 == ADDR_CMD_STATE);
  assign pslverr = psel && penable && !hit;

  // byte-lane merge; reserved lanes are simply dropped by the field masks
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        r[8*i +: 8] = new_v[8*i +: 8];
    return r;
  endfunction : merge

  logic [31:0] wdata_eff;
  assign wdata_eff = merge(32'h0000_0000, pwdata, pstrb);

  ////////////////////////////////////////////////////////////////////////
  // soft reset pulse from the command-state register

  logic soft_reset;
  assign soft_reset = wr_en && (addr12 == ADDR_CMD_STATE) &&
                      wdata_eff[SOFT_RESET_BIT];

  ////////////////////////////////////////////////////////////////////////
  // interrupt mask and global gate

  logic [SRC_W-1:0] mask_q;
  logic             gate_q;

  // set via the set register, clear via the clear register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mask_q <= 7'h00;
      gate_q <= 1'b0;
    end
    else if (soft_reset)
    begin
      mask_q <= 7'h00;
      gate_q <= 1'b0;
    end
    else if (wr_en && addr12 == ADDR_MASK_SET)
    begin
      mask_q <= mask_q | (wdata_eff[SRC_W-1:0] & SRC_VALID);
      gate_q <= gate_q | wdata_eff[GATE_BIT];
    end
    else if (wr_en && addr12 == ADDR_MASK_CLEAR)
    begin
      mask_q <= mask_q & ~(wdata_eff[SRC_W-1:0] & SRC_VALID);
      gate_q <= gate_q & ~wdata_eff[GATE_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sticky source flags, write one to clear; a new event wins over clear

  logic [SRC_W-1:0] flags_q;
  logic [SRC_W-1:0] ev_all;
  logic [SRC_W-1:0] flag_clr;

  assign flag_clr = (wr_en && addr12 == ADDR_SRC_FLAGS) ?
                    wdata_eff[SRC_W-1:0] : 7'h00;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      flags_q <= 7'h00;
    else if (soft_reset)
      flags_q <= 7'h00;
    else
      flags_q <= ((flags_q & ~flag_clr) | ev_all) & SRC_VALID;
  end

  assign irq = gate_q && |(flags_q & mask_q);

  ////////////////////////////////////////////////////////////////////////
  // frame-length register

  logic [LEN_W-1:0]  len_q;
  logic [MAXB_W-1:0] maxb_q;
  logic              flip_q;

  // writable at any time; the counter takes a new length at its next reload
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      len_q  <= LEN_NOMINAL;
      maxb_q <= MAXB_RESET;
      flip_q <= FLIP_RESET;
    end
    else if (soft_reset)
      len_q  <= LEN_NOMINAL;
    else if (wr_en && addr12 == ADDR_FRAME_LEN)
    begin
      len_q  <= wdata_eff[LEN_LSB +: LEN_W];
      maxb_q <= wdata_eff[MAXB_LSB +: MAXB_W];
      flip_q <= wdata_eff[FLIP_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // bit-time enable divider

  logic [3:0] div_q;
  logic       bit_tick;

  assign bit_tick = (div_q == BIT_CYC_LAST);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      div_q <= 4'h0;
    else if (bit_tick)
      div_q <= 4'h0;
    else
      div_q <= div_q + 4'h1;
  end

  ////////////////////////////////////////////////////////////////////////
  // bits-left down counter and its toggle

  logic [LEN_W-1:0] left_q;
  logic             left_flip_q;
  logic             at_zero;
  logic             frame_begin_q;

  assign at_zero = (left_q == 14'h0000);

  // reload on the bit boundary after zero; toggle copied at the same point
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      left_q        <= 14'h0000;
      left_flip_q   <= 1'b0;
      frame_begin_q <= 1'b0;
    end
    else
    begin
      frame_begin_q <= 1'b0;
      if (bit_tick)
      begin
        if (at_zero)
        begin
          left_q        <= len_q;
          left_flip_q   <= flip_q;
          frame_begin_q <= 1'b1;
        end
        else
          left_q <= left_q - 14'h0001;
      end
    end
  end

  assign frame_begin = frame_begin_q;

  // largest-transfer counter loaded at each frame start
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      max_transfer_count <= 15'h0000;
    else if (frame_begin_q)
      max_transfer_count <= maxb_q;
  end

  // internal frame events join the external ones
  always_comb
  begin
    ev_all = src_event & SRC_VALID;
    ev_all[FRAME_BEGIN_BIT] = src_event[FRAME_BEGIN_BIT] | frame_begin_q;
  end

  ////////////////////////////////////////////////////////////////////////
  // read mux, registered so read data comes from flip-flops

  logic [31:0] rd_d;

  always_comb
  begin
    rd_d = 32'h0000_0000;
    unique case (addr12)
      ADDR_MASK_SET,
      ADDR_MASK_CLEAR: rd_d = {gate_q, 24'h000000, mask_q};
      ADDR_FRAME_LEN:  rd_d = {flip_q, maxb_q, 2'b00, len_q};
      ADDR_FRAME_LEFT: rd_d = {left_flip_q, 17'h00000, left_q};
      ADDR_SRC_FLAGS:  rd_d = {25'h0000000, flags_q};
      default:         rd_d = 32'h0000_0000;
    endcase
  end

  // captured in the setup cycle, held through the access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
      prdata <= rd_d;
  end

endmodule : frame_irq_regs

`default_nettype wire

// *** testbench/frame_irq_regs_sva.sv ***
/*
  Port-level checker for the mask and frame-interval register bank.
  Assumes one pclk domain and zero-wait apb answers.
*/
`timescale 1ns/1ps
`default_nettype none
module frame_irq_regs_sva
  import frame_irq_pkg::*;
#(
  parameter int ADDR_W = 12
)
(
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [3:0]        pstrb,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic [SRC_W-1:0]  src_event,
  input wire logic              irq,
  input wire logic              frame_begin,
  input wire logic [MAXB_W-1:0] max_transfer_count
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // write taking effect at this edge
  sequence s_wr(a);
    psel && penable && pwrite && paddr == a;
  endsequence
  // gate bit lives in byte lane three
  AST_GATE_CLEAR: assert property (s_wr(ADDR_MASK_CLEAR) ##0 (pwdata[GATE_BIT] && pstrb[3])
    |=> !irq)
    else $error("irq still high after gate clear");
  // frame starts set a flag of their own, so they are kept out of these two
  AST_CLR_NO_RISE: assert property (s_wr(ADDR_MASK_CLEAR) ##0 (src_event == '0 && !frame_begin)
    |=> !$rose(irq))
    else $error("irq rose on a mask clear");
  AST_CLR_ZERO_KEEP: assert property (s_wr(ADDR_MASK_CLEAR) ##0
    (pwdata == '0 && src_event == '0 && !frame_begin) |=> $stable(irq))
    else $error("zero clear write moved irq");
  // irq may only move through an event, a frame start or a register write
  AST_IRQ_CAUSE: assert property ($rose(irq) |->
    $past(src_event != '0 || frame_begin || (psel && penable && pwrite)))
    else $error("irq rose without cause");
  AST_IRQ_DROP: assert property ($fell(irq) |-> $past(psel && penable && pwrite))
    else $error("irq fell without a write");
  AST_CLR_MAPPED: assert property (psel && penable && paddr == ADDR_MASK_CLEAR |->
    pready && !pslverr)
    else $error("mask clear access refused");
  AST_LEN_MAPPED: assert property (psel && penable && paddr == ADDR_FRAME_LEN |->
    pready && !pslverr)
    else $error("frame length access refused");
  // reloads happen on bit boundaries, eight clocks apart at least
  AST_FRAME_GAP: assert property (frame_begin |=> !frame_begin [*7])
    else $error("frame pulses too close");
  AST_MAX_LOAD: assert property ($changed(max_transfer_count) |->
    frame_begin || $past(frame_begin))
    else $error("max count moved outside frame start");
  // a refused write leaves the last read word on the bus, so reads only
  AST_ERR_ZERO: assert property (pslverr && !pwrite |-> prdata == '0)
    else $error("refused read returned data");
endmodule : frame_irq_regs_sva
bind frame_irq_regs frame_irq_regs_sva #(.ADDR_W(ADDR_W)) u_sva (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .src_event(src_event), .irq(irq),
  .frame_begin(frame_begin), .max_transfer_count(max_transfer_count));
`default_nettype wire

// *** testbench/host_driver_model.sv ***
/*
  Host software model: apb master that notes each expected read.
  Assumes a zero or more wait-state slave; hang flags a stuck wait.
*/
`timescale 1ns/1ps
`default_nettype none
module host_driver_model
(
  input  wire logic pclk,
  input  wire logic pready,
  output logic      psel,
  output logic      penable,
  output logic      pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0]  pstrb,
  output logic      hang
);
  logic [65:0] exp_q[$]; // {mask, expected}, pslverr on top of each
  initial
  begin
    {psel, penable, pwrite, hang} = '0;
    paddr = '0;
    pwdata = '0;
    pstrb = 4'hF;
  end
  ////////////////////////////////////////
  // released bus shows inverted values so stale data never passes
  task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (n >= 50) hang <= 1'b1;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask : xfer
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [32:0] e, input logic [32:0] m);
    exp_q.push_back({m, e});
    xfer(a, 1'b0, 32'h0);
  endtask : rd
endmodule : host_driver_model
`default_nettype wire

// *** testbench/tb_host_irq_mask_clear_and_frame_interval.sv ***
/*
  Self-checking bench for the register bank; host model drives apb.
  Assumes the design answers every transfer without wait states.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_host_irq_mask_clear_and_frame_interval;
  import frame_irq_pkg::*;
  localparam logic [32:0] ALL = 33'h1FFFFFFFF;
  localparam logic [31:0] MASK_NOW = 32'h8000003C;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, frame_begin, hang;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, lfsr, fl;
  logic [3:0] pstrb;
  logic [SRC_W-1:0] src_event;
  logic [MAXB_W-1:0] max_transfer_count, maxb;
  logic [65:0] mon_e;
  int num_errors, n_compared, n;
  int src_bits[6] = '{6, 5, 4, 3, 2, 0};
  frame_irq_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .src_event(src_event), .irq(irq),
    .frame_begin(frame_begin), .max_transfer_count(max_transfer_count));
  host_driver_model u_host (.pclk(pclk), .pready(pready), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .hang(hang));
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic finish_test;
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : finish_test
  task automatic wait_frame(output int c);
    c = 0;
    do
    begin
      @(negedge pclk);
      c++;
    end
    while (frame_begin !== 1'b1 && c < 2000);
    if (c >= 2000)
    begin
      num_errors++;
      finish_test();
    end
  endtask : wait_frame
  task automatic pulse(input logic [SRC_W-1:0] ev);
    @(posedge pclk) src_event <= ev;
    @(posedge pclk) src_event <= '0;
    @(negedge pclk);
  endtask : pulse
  ////////////////////////////////////////
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // read monitor: each completed read is matched with the oldest note
  always @(posedge pclk)
    if (psel && penable && pready && !pwrite)
    begin
      mon_e = u_host.exp_q.pop_front();
      check({pslverr, prdata} & mon_e[65:33], mon_e[32:0]);
    end
  always @(posedge hang)
  begin
    num_errors++;
    finish_test();
  end
  initial
  begin
    repeat (60000) @(posedge pclk);
    num_errors++;
    finish_test();
  end
  initial
  begin
    presetn = 1'b0;
    src_event = '0;
    lfsr = lfsr_next(32'h793F);
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    // short frame written before the first reload, so frames stay brief
    maxb = lfsr[14:0];
    fl = {1'b1, maxb, 2'h0, 14'h0003};
    u_host.wr(ADDR_FRAME_LEN, fl | 32'h0000C000);
    u_host.rd(ADDR_FRAME_LEN, {1'b0, fl}, ALL);
    wait_frame(n);
    wait_frame(n);
    check(33'(n), 33'(4 * BIT_CYCLES));
    @(negedge pclk);
    check({18'h0, max_transfer_count}, {18'h0, maxb});
    u_host.rd(ADDR_FRAME_LEFT, 33'h080000000, 33'h080000000);
    // long frame next, so no frame-start flag lands inside the irq checks
    fl[FLIP_BIT] = ~fl[FLIP_BIT];
    fl[LEN_W-1:0] = 14'h0FFF;
    u_host.wr(ADDR_FRAME_LEN, fl);
    repeat (8 * BIT_CYCLES) @(posedge pclk);
    u_host.wr(ADDR_SRC_FLAGS, 32'h0000007F);
    u_host.wr(ADDR_MASK_SET, 32'hFFFFFFFF);
    u_host.rd(ADDR_MASK_CLEAR, 33'h08000007D, ALL);
    u_host.wr(ADDR_MASK_CLEAR, 32'h00000041);
    u_host.rd(ADDR_MASK_CLEAR, {1'b0, MASK_NOW}, ALL);
    foreach (src_bits[k])
    begin
      pulse(SRC_W'(1) << src_bits[k]);
      check({32'h0, irq}, {32'h0, MASK_NOW[src_bits[k]]});
      u_host.wr(ADDR_SRC_FLAGS, 32'h0000007F);
    end
    lfsr = lfsr_next(lfsr);
    pulse((lfsr[6:0] & SRC_VALID) | 7'h04);
    check({32'h0, irq}, 33'h1);
    u_host.wr(ADDR_MASK_CLEAR, 32'h80000000);
    @(negedge pclk);
    check({32'h0, irq}, 33'h0);
    u_host.rd(ADDR_MASK_CLEAR, 33'h00000003C, ALL);
    u_host.rd(12'hFFC, 33'h100000000, ALL);
    u_host.rd(ADDR_FRAME_LEN, {1'b0, fl}, ALL);
    u_host.wr(ADDR_CMD_STATE, 32'h00000001);
    u_host.rd(ADDR_FRAME_LEN, {1'b0, fl[31:14], LEN_NOMINAL}, ALL);
    fl[FLIP_BIT] = ~fl[FLIP_BIT];
    u_host.wr(ADDR_FRAME_LEN, fl);
    u_host.rd(ADDR_FRAME_LEN, {1'b0, fl}, ALL);
    @(posedge pclk) presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    check({18'h0, max_transfer_count}, 33'h0);
    presetn <= 1'b1;
    u_host.rd(ADDR_FRAME_LEN, {19'h0, LEN_NOMINAL}, ALL);
    u_host.rd(ADDR_MASK_CLEAR, 33'h0, ALL);
    repeat (3) @(posedge pclk);
    finish_test();
  end
endmodule : tb_host_irq_mask_clear_and_frame_interval
`default_nettype wire
